/* File: rtl/adc_ctrl.sv */
// Contract
// [RULE1] enable bit powers converter, clearing aborts
// [RULE2] start bit launches one or first conversion
// [RULE3] first conversion 25 clocks, later 13
// [RULE4] start reads one while busy, zero-write ignored
// [RULE5] auto-trigger starts on selected rising edge
// [RULE6] done flag set on completion, gated irq
// [RULE7] flag cleared by vector or writing one
// [RULE8] irq enable and global enable gate irq
// [RULE9] prescaler divides by 2 up to 128
// [RULE10] right adjust places result in low bits
// [RULE11] left adjust places result in high bits
// [RULE12] differential result in two's complement
// [RULE13] low-byte read locks result until high read
// [RULE14] software writes zero to reserved bit
// [RULE15] trigger source ignored without auto-trigger
// [RULE16] switching to set source gives rising edge
// [RULE17] selecting free running causes no trigger
// [RULE18] trigger codes map to eight sources
// [RULE19] no free running with differential channels; not enforced, free running also runs on differential channels
// [RULE20] left adjust change shows immediately
// [RULE21] channel change waits for conversion end
module adc_ctrl #(
	parameter int ADDR_W = 12
) (
	input  wire logic              CORE_CLK,
	input  wire logic              SRST,
	input  wire logic              CE,
	input  wire logic [ADDR_W-1:0] AWADDR,
	input  wire logic              AWVALID,
	output      logic              AWREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	input  wire logic              WVALID,
	output      logic              WREADY,
	output      logic [1:0]        BRESP,
	output      logic              BVALID,
	input  wire logic              BREADY,
	input  wire logic [ADDR_W-1:0] ARADDR,
	input  wire logic              ARVALID,
	output      logic              ARREADY,
	output      logic [31:0]       RDATA,
	output      logic [1:0]        RRESP,
	output      logic              RVALID,
	input  wire logic              RREADY,
	input  wire logic [6:0]        TRIG_FLAGS,
	input  wire logic              GLOBAL_IRQ_EN,
	input  wire logic              IRQ_ACK,
	input  wire logic [9:0]        SAMPLE_CODE,
	output      logic              IRQ,
	output      logic              CONV_POWER,
	output      logic              CONV_BUSY,
	output      logic [5:0]        CONV_CHANNEL
);

	if (ADDR_W < 10)
	begin : g_bad_addr_w
		$error("ADDR_W too small to reach the register indices");
	end

	typedef struct packed {
		adc_ctrl_pkg::conv_state_t state;
		logic                      en;
		logic                      ate;
		logic                      flag;
		logic                      ie;
		logic [2:0]                ps;
		logic                      acme;
		logic                      mux5;
		logic [2:0]                ts;
		logic                      ladj;
		logic [4:0]                chan;
		logic [5:0]                act_chan;
		logic                      init_done;
		logic                      first;
		logic [6:0]                pre_cnt;
		logic [4:0]                tick_cnt;
		logic [9:0]                result;
		logic                      lock;
		logic                      done_pulse;
		logic                      trig_prev;
		logic                      aw_got;
		logic [ADDR_W-1:0]         aw_addr;
		logic                      w_got;
		logic [7:0]                wdata;
		logic                      wlane;
		logic                      bvalid;
		logic [1:0]                bresp;
		logic                      rvalid;
		logic [1:0]                rresp;
		logic [7:0]                rdata;
	} regs_t;

	localparam regs_t REGS_INIT = '0;

	regs_t                  state_reg;
	regs_t                  state_next;
	adc_ctrl_pkg::reg_sel_t wsel;
	adc_ctrl_pkg::reg_sel_t rsel;
	logic                   do_wr;
	logic                   wr_en;
	logic                   sw_start;
	logic                   flag_clr;
	logic                   sel_sig;
	logic                   trig_edge;
	logic                   tick;
	logic                   complete;
	logic                   lo_read;
	logic [4:0]             conv_last;
	logic [9:0]             conv_val;
	logic [7:0]             lo_view;
	logic [7:0]             hi_view;

	// address decode: unmapped indices answer with a slave error
	function automatic adc_ctrl_pkg::reg_sel_t decode(
		input logic [ADDR_W-1:0] a);
		logic [ADDR_W-3:0] idx;
		idx = a[ADDR_W-1:2];
		if (idx == (ADDR_W-2)'(adc_ctrl_pkg::IDX_RES_LO))
			decode = adc_ctrl_pkg::SEL_LO;
		else if (idx == (ADDR_W-2)'(adc_ctrl_pkg::IDX_RES_HI))
			decode = adc_ctrl_pkg::SEL_HI;
		else if (idx == (ADDR_W-2)'(adc_ctrl_pkg::IDX_CTRL_A))
			decode = adc_ctrl_pkg::SEL_CA;
		else if (idx == (ADDR_W-2)'(adc_ctrl_pkg::IDX_CTRL_B))
			decode = adc_ctrl_pkg::SEL_CB;
		else if (idx == (ADDR_W-2)'(adc_ctrl_pkg::IDX_CH_CFG))
			decode = adc_ctrl_pkg::SEL_CFG;
		else
			decode = adc_ctrl_pkg::SEL_NONE;
	endfunction

	// readies drop while frozen so no beat is lost
	assign AWREADY = CE && !state_reg.aw_got && !state_reg.bvalid;
	assign WREADY  = CE && !state_reg.w_got && !state_reg.bvalid;
	assign ARREADY = CE && !state_reg.rvalid;
	assign BVALID  = state_reg.bvalid;
	assign BRESP   = state_reg.bresp;
	assign RVALID  = state_reg.rvalid;
	assign RRESP   = state_reg.rresp;
	assign RDATA   = {24'h000000, state_reg.rdata};
	assign IRQ     = state_reg.flag && state_reg.ie
		&& GLOBAL_IRQ_EN; // see [RULE6] see [RULE8]
	assign CONV_POWER   = state_reg.en; // see [RULE1]
	assign CONV_BUSY    = state_reg.state == adc_ctrl_pkg::S_CONV;
	assign CONV_CHANNEL = state_reg.act_chan;

	// live left-adjust view, no resampling needed
	always_comb
	begin
		if (state_reg.ladj)
		begin
			lo_view = {state_reg.result[1:0], 6'h00}; // see [RULE11]
			hi_view = state_reg.result[9:2]; // see [RULE20]
		end
		else
		begin
			lo_view = state_reg.result[7:0]; // see [RULE10]
			hi_view = {6'h00, state_reg.result[9:8]};
		end
	end

	// all next-state logic
	always_comb
	begin
		state_next = state_reg;
		state_next.done_pulse = 1'b0;
		sw_start = 1'b0;
		lo_read = 1'b0;
		complete = 1'b0;
		tick = 1'b0;
		wsel = decode(state_reg.aw_addr);
		rsel = decode(ARADDR);
		do_wr = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
		wr_en = do_wr && state_reg.wlane;
		conv_last = (state_reg.first ? adc_ctrl_pkg::FIRST_CONV_CLKS
			: adc_ctrl_pkg::NORMAL_CONV_CLKS) - 5'h01; // see [RULE3]
		conv_val = SAMPLE_CODE;
		if (adc_ctrl_pkg::is_diff(state_reg.act_chan))
			conv_val[9] = ~SAMPLE_CODE[9]; // see [RULE12]
		// code 0 follows completion, others the peripheral flags
		if (state_reg.ts == 3'h0)
			sel_sig = state_reg.done_pulse; // see [RULE17]
		else
			sel_sig = TRIG_FLAGS[3'(state_reg.ts - 3'h1)]; // see [RULE18]
		state_next.trig_prev = sel_sig; // see [RULE16]
		trig_edge = state_reg.ate && sel_sig
			&& !state_reg.trig_prev; // see [RULE5] see [RULE15]
		flag_clr = IRQ_ACK || (wr_en && wsel == adc_ctrl_pkg::SEL_CA
			&& state_reg.wdata[adc_ctrl_pkg::CA_FLAG]); // see [RULE7]

		// write address and data are taken in either order
		if (AWVALID && AWREADY)
		begin
			state_next.aw_got = 1'b1;
			state_next.aw_addr = AWADDR;
		end
		if (WVALID && WREADY)
		begin
			state_next.w_got = 1'b1;
			state_next.wdata = WDATA[7:0];
			state_next.wlane = WSTRB[0];
		end
		if (do_wr)
		begin
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = (wsel == adc_ctrl_pkg::SEL_NONE)
				? adc_ctrl_pkg::RESP_SLVERR : adc_ctrl_pkg::RESP_OKAY;
		end
		if (state_reg.bvalid && BREADY)
			state_next.bvalid = 1'b0;

		// register writes; result bytes are read-only
		if (wr_en)
		begin
			unique case (wsel)
				adc_ctrl_pkg::SEL_CA:
				begin
					state_next.en = state_reg.wdata[adc_ctrl_pkg::CA_EN];
					state_next.ate = state_reg.wdata[adc_ctrl_pkg::CA_ATE];
					state_next.ie = state_reg.wdata[adc_ctrl_pkg::CA_IE];
					state_next.ps = state_reg.wdata[2:0];
					// a zero here does nothing
					sw_start = state_reg.wdata[adc_ctrl_pkg::CA_START]; // see [RULE4]
				end
				adc_ctrl_pkg::SEL_CB:
				begin
					// bit 7 is dropped, reads zero
					state_next.acme = state_reg.wdata[adc_ctrl_pkg::CB_ACME]; // see [RULE14]
					state_next.mux5 = state_reg.wdata[adc_ctrl_pkg::CB_MUX5];
					state_next.ts = state_reg.wdata[2:0];
				end
				adc_ctrl_pkg::SEL_CFG:
				begin
					state_next.ladj = state_reg.wdata[adc_ctrl_pkg::CFG_LADJ];
					state_next.chan = state_reg.wdata[4:0];
				end
				default:
				begin
				end
			endcase
		end

		// reads; the byte order sets and releases the result lock
		if (ARVALID && ARREADY)
		begin
			state_next.rvalid = 1'b1;
			state_next.rresp = adc_ctrl_pkg::RESP_OKAY;
			unique case (rsel)
				adc_ctrl_pkg::SEL_LO:
				begin
					state_next.rdata = lo_view;
					state_next.lock = 1'b1; // see [RULE13]
					lo_read = 1'b1;
				end
				adc_ctrl_pkg::SEL_HI:
				begin
					state_next.rdata = hi_view;
					state_next.lock = 1'b0; // see [RULE13]
				end
				adc_ctrl_pkg::SEL_CA:
					state_next.rdata = {state_reg.en,
						state_reg.state == adc_ctrl_pkg::S_CONV, // see [RULE4]
						state_reg.ate, state_reg.flag, state_reg.ie,
						state_reg.ps};
				adc_ctrl_pkg::SEL_CB:
					state_next.rdata = {1'b0, state_reg.acme, 2'h0,
						state_reg.mux5, state_reg.ts};
				adc_ctrl_pkg::SEL_CFG:
					state_next.rdata = {2'h0, state_reg.ladj,
						state_reg.chan};
				default:
				begin
					state_next.rdata = 8'h00;
					state_next.rresp = adc_ctrl_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (state_reg.rvalid && RREADY)
			state_next.rvalid = 1'b0;

		// conversion sequencer; prescaler restarts with each conversion
		unique case (state_reg.state)
			adc_ctrl_pkg::S_IDLE:
			begin
				// channel follows software only between conversions
				state_next.act_chan = {state_next.mux5,
					state_next.chan}; // see [RULE21]
				if (state_next.en && (sw_start || trig_edge)) // see [RULE2]
				begin
					state_next.state = adc_ctrl_pkg::S_CONV;
					state_next.first = !state_reg.init_done; // see [RULE3]
					state_next.init_done = 1'b1;
					state_next.pre_cnt = 7'h00;
					state_next.tick_cnt = 5'h00;
				end
			end
			adc_ctrl_pkg::S_CONV:
			begin
				// >= copes with a divider lowered mid-conversion
				tick = state_reg.pre_cnt
					>= adc_ctrl_pkg::div_last(state_reg.ps); // see [RULE9]
				state_next.pre_cnt = tick ? 7'h00
					: state_reg.pre_cnt + 7'h01;
				if (tick && state_reg.tick_cnt == conv_last
					&& state_next.en)
				begin
					complete = 1'b1;
					state_next.state = adc_ctrl_pkg::S_IDLE;
					state_next.done_pulse = 1'b1;
					if (!state_reg.lock && !lo_read)
						state_next.result = conv_val; // see [RULE13]
				end
				else if (tick)
					state_next.tick_cnt = state_reg.tick_cnt + 5'h01;
			end
		endcase

		// set wins over any clear in the same cycle
		state_next.flag = (state_reg.flag && !flag_clr)
			|| complete; // see [RULE6] see [RULE7]

		// switching off aborts and forces the next long conversion
		if (!state_next.en)
		begin
			state_next.state = adc_ctrl_pkg::S_IDLE; // see [RULE1]
			state_next.init_done = 1'b0;
		end
	end

	// single state register, frozen while CE is low
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST)
			state_reg <= REGS_INIT;
		else if (CE)
			state_reg <= state_next;
	end

	// checks
	sequence seq_start_taken;
		state_reg.state == adc_ctrl_pkg::S_IDLE && state_next.en
			&& (sw_start || trig_edge);
	endsequence

	sequence seq_running;
		state_reg.state == adc_ctrl_pkg::S_CONV;
	endsequence

	chk_disable_aborts: assert property (@(posedge CORE_CLK) // see [RULE1]
		disable iff (SRST || !CE)
		$fell(state_reg.en) |-> !CONV_BUSY && !state_reg.init_done)
		else $error("conversion survived disable");

	chk_start_launch: assert property (@(posedge CORE_CLK) // see [RULE2]
		disable iff (SRST || !CE)
		seq_start_taken |=> seq_running)
		else $error("start did not launch a conversion");

	chk_conv_length: assert property (@(posedge CORE_CLK) // see [RULE3]
		disable iff (SRST || !CE)
		complete |-> state_reg.tick_cnt == (state_reg.first
			? 5'h18 : 5'h0C))
		else $error("conversion length wrong");

	chk_busy_clears: assert property (@(posedge CORE_CLK) // see [RULE4]
		disable iff (SRST || !CE)
		complete |=> !CONV_BUSY ##1 (!CONV_BUSY || state_reg.ate))
		else $error("busy did not drop at completion");

	chk_trigger_start: assert property (@(posedge CORE_CLK) // see [RULE5]
		disable iff (SRST || !CE)
		sel_sig && !state_reg.trig_prev && state_reg.ate
			&& state_next.en && !CONV_BUSY |=> seq_running)
		else $error("trigger edge did not start a conversion");

	chk_done_flag: assert property (@(posedge CORE_CLK) // see [RULE6]
		disable iff (SRST || !CE)
		complete |=> state_reg.flag && state_reg.done_pulse)
		else $error("done flag not set at completion");

	chk_ack_clears: assert property (@(posedge CORE_CLK) // see [RULE7]
		disable iff (SRST || !CE)
		IRQ_ACK && !complete |=> !state_reg.flag)
		else $error("vector did not clear the flag");

	chk_irq_gate: assert property (@(posedge CORE_CLK) // see [RULE8]
		disable iff (SRST || !CE)
		IRQ |-> state_reg.ie && GLOBAL_IRQ_EN && state_reg.flag)
		else $error("interrupt not gated");

	chk_lock_holds: assert property (@(posedge CORE_CLK) // see [RULE13]
		disable iff (SRST || !CE)
		state_reg.lock && complete |=> $stable(state_reg.result))
		else $error("locked result was overwritten");

	chk_freerun_quiet: assert property (@(posedge CORE_CLK) // see [RULE17]
		disable iff (SRST || !CE)
		state_reg.ts == 3'h0 && $past(state_reg.ts) != 3'h0
			&& !$past(complete) |-> !trig_edge)
		else $error("free-running select made a trigger");

	chk_chan_held: assert property (@(posedge CORE_CLK) // see [RULE21]
		disable iff (SRST || !CE)
		seq_running ##1 seq_running |-> $stable(state_reg.act_chan))
		else $error("channel changed mid-conversion");

endmodule // adc_ctrl

/* File: rtl/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_RES_LO  = 8'h78;
	localparam logic [7:0] IDX_RES_HI  = 8'h79;
	localparam logic [7:0] IDX_CTRL_A  = 8'h7A;
	localparam logic [7:0] IDX_CTRL_B  = 8'h7B;
	localparam logic [7:0] IDX_CH_CFG  = 8'h7C;

	// converter_control_a fields
	localparam int CA_EN     = 7;
	localparam int CA_START  = 6;
	localparam int CA_ATE    = 5;
	localparam int CA_FLAG   = 4;
	localparam int CA_IE     = 3;
	// converter_control_b fields
	localparam int CB_ACME   = 6;
	localparam int CB_MUX5   = 3;
	// channel configuration fields
	localparam int CFG_LADJ  = 5;

	// conversion lengths in converter clocks: 25 first, 13 later
	localparam logic [4:0] FIRST_CONV_CLKS  = 5'h19;
	localparam logic [4:0] NORMAL_CONV_CLKS = 5'h0D;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SEL_LO   = 3'h0,
		SEL_HI   = 3'h1,
		SEL_CA   = 3'h2,
		SEL_CB   = 3'h3,
		SEL_CFG  = 3'h4,
		SEL_NONE = 3'h7
	} reg_sel_t;

	typedef enum logic {
		S_IDLE = 1'b0,
		S_CONV = 1'b1
	} conv_state_t;

	// last prescaler count: codes 0 and 1 divide by 2, then 4..128
	function automatic logic [6:0] div_last(input logic [2:0] code);
		logic [7:0] d;
		d = 8'h01 << code;
		div_last = (code < 3'h2) ? 7'h01 : d[6:0] - 7'h01;
	endfunction

	// every code outside the single-ended groups is differential
	function automatic logic is_diff(input logic [5:0] ch);
		is_diff = (ch[4:3] != 2'h0) && (ch[4:0] != 5'h1E)
			&& (ch[4:0] != 5'h1F);
	endfunction

endpackage

/* File: tb/adc_ctrl_tb_top.sv */
module adc_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic        CORE_CLK = 1'b0;
	logic        SRST = 1'b1;
	logic [11:0] AWADDR = 12'h000;
	logic [11:0] ARADDR = 12'h000;
	logic        AWVALID = 1'b0;
	logic        WVALID = 1'b0;
	logic        ARVALID = 1'b0;
	logic [31:0] WDATA = 32'h0;
	logic [6:0]  TRIG_FLAGS = 7'h00;
	logic        GLOBAL_IRQ_EN = 1'b0;
	logic        IRQ_ACK = 1'b0;
	logic [9:0]  SAMPLE_CODE = 10'h000;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
	logic        CONV_POWER, CONV_BUSY;
	logic [1:0]  BRESP, RRESP, rr;
	logic [31:0] RDATA;
	logic [5:0]  CONV_CHANNEL;
	logic [31:0] seed = 32'h53576EEA;
	logic [7:0]  rv;
	logic [9:0]  c;
	logic [15:0] e;
	logic        s;
	int          failures = 0;
	int          n_tests = 0;
	int          busy_cnt = 0;
	int          b0, bl;

	// clock enable, strobes and response readies held on throughout
	adc_ctrl i_adc_ctrl (
		.CORE_CLK(CORE_CLK), .SRST(SRST), .CE(1'b1),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(1'b1),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(1'b1),
		.TRIG_FLAGS(TRIG_FLAGS), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
		.IRQ_ACK(IRQ_ACK), .SAMPLE_CODE(SAMPLE_CODE), .IRQ(IRQ),
		.CONV_POWER(CONV_POWER), .CONV_BUSY(CONV_BUSY),
		.CONV_CHANNEL(CONV_CHANNEL)
	);

	// 40 MHz core clock
	always #12.5 CORE_CLK = ~CORE_CLK;

	// busy-cycle tally, differenced to time each conversion
	always @(posedge CORE_CLK)
		if (CONV_BUSY === 1'b1)
			busy_cnt <= busy_cnt + 1;

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// expected {high, low} bytes; differential flips the sign bit
	function automatic logic [15:0] res(input logic [9:0] v,
		input logic l, input logic d);
		logic [9:0] x;
		x = d ? v ^ 10'h200 : v;
		return l ? {x, 6'h00} : {6'h00, x};
	endfunction

	// expected busy cycles: converter clocks times core clocks per tick
	function automatic int conv_len(input logic f, input int p);
		int n;
		n = f ? int'(adc_ctrl_pkg::FIRST_CONV_CLKS)
			: int'(adc_ctrl_pkg::NORMAL_CONV_CLKS);
		return n * (p < 2 ? 2 : 1 << p);
	endfunction

	task automatic chk(input string n, input logic [15:0] sv, ev);
		n_tests++;
		if (sv !== ev)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, ev, sv);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic a, w, b, ta, tw;
		a = 1'b0;
		w = 1'b0;
		b = 1'b0;
		AWADDR <= {2'h0, i, 2'h0};
		WDATA <= {24'h0, d};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		while (!b)
		begin
			@(negedge CORE_CLK);
			ta = !a && AWREADY;
			tw = !w && WREADY;
			b = a && w && BVALID;
			rr = BRESP;
			@(posedge CORE_CLK);
			if (ta)
				AWVALID <= 1'b0;
			if (tw)
				WVALID <= 1'b0;
			a = a | ta;
			w = w | tw;
		end
	endtask

	task automatic rc(input logic [7:0] i, input string n,
		input logic [7:0] ev);
		logic a, g, ta;
		a = 1'b0;
		g = 1'b0;
		ARADDR <= {2'h0, i, 2'h0};
		ARVALID <= 1'b1;
		while (!g)
		begin
			@(negedge CORE_CLK);
			ta = !a && ARREADY;
			g = a && RVALID;
			rv = RDATA[7:0];
			rr = RRESP;
			@(posedge CORE_CLK);
			if (ta)
				ARVALID <= 1'b0;
			a = a | ta;
		end
		chk(n, rv, ev);
	endtask

	task automatic wait_idle();
		do
			@(negedge CORE_CLK);
		while (CONV_BUSY === 1'b1);
		bl = busy_cnt - b0;
		@(posedge CORE_CLK);
	endtask

	// did a conversion show up within four cycles
	task automatic sb();
		s = 1'b0;
		repeat (4)
		begin
			@(negedge CORE_CLK);
			if (CONV_BUSY === 1'b1)
				s = 1'b1;
		end
		@(posedge CORE_CLK);
	endtask

	// main sequence
	initial
	begin
		repeat (10) @(posedge CORE_CLK);
		SRST <= 1'b0;
		for (int i = 0; i < 4; i++)
			rc(adc_ctrl_pkg::IDX_RES_LO + 8'(i), "reset", 8'h00);
		rc(8'h7D, "unmapped rd", 8'h00);
		chk("unmapped rresp", rr, 2'h2);
		wr(8'h7D, 8'hFF);
		chk("unmapped bresp", rr, 2'h2);
		// every divider code; only the first conversion is long
		for (int p = 0; p < 8; p++)
		begin
			c = 10'(xs());
			SAMPLE_CODE <= c;
			b0 = busy_cnt;
			wr(adc_ctrl_pkg::IDX_CTRL_A, 8'hC0 | 8'(p));
			rc(adc_ctrl_pkg::IDX_CTRL_A, "busy",
				8'hC0 | 8'(p));
			// a zero start written mid-conversion must not stop it
			wr(adc_ctrl_pkg::IDX_CTRL_A, 8'h80 | 8'(p));
			rc(adc_ctrl_pkg::IDX_CTRL_A, "zero start",
				8'hC0 | 8'(p));
			wait_idle();
			chk("length", 16'(bl),
				16'(conv_len(p == 0, p)));
			rc(adc_ctrl_pkg::IDX_CTRL_A, "done",
				8'h90 | 8'(p));
			e = res(c, 1'b0, 1'b0);
			rc(adc_ctrl_pkg::IDX_RES_LO, "right lo", e[7:0]);
			rc(adc_ctrl_pkg::IDX_RES_HI, "right hi", e[15:8]);
			wr(adc_ctrl_pkg::IDX_CTRL_A, 8'h90 | 8'(p));
		end
		// interrupt gating and both ways of clearing the flag
		wr(adc_ctrl_pkg::IDX_CTRL_A, 8'hC8);
		wait_idle();
		chk("irq gie off", IRQ, 1'b0);
		GLOBAL_IRQ_EN <= 1'b1;
		@(negedge CORE_CLK);
		chk("irq on", IRQ, 1'b1);
		@(posedge CORE_CLK);
		IRQ_ACK <= 1'b1;
		@(posedge CORE_CLK);
		IRQ_ACK <= 1'b0;
		@(negedge CORE_CLK);
		chk("irq vector", IRQ, 1'b0);
		@(posedge CORE_CLK);
		wr(adc_ctrl_pkg::IDX_CTRL_A, 8'hC8);
		wait_idle();
		wr(adc_ctrl_pkg::IDX_CTRL_A, 8'h88);
		rc(adc_ctrl_pkg::IDX_CTRL_A, "flag w0", 8'h98);
		wr(adc_ctrl_pkg::IDX_CTRL_A, 8'h98);
		rc(adc_ctrl_pkg::IDX_CTRL_A, "flag w1", 8'h88);
		// low read locks the pair against a newer result
		c = 10'(xs());
		SAMPLE_CODE <= c;
		wr(adc_ctrl_pkg::IDX_CTRL_A, 8'hC0);
		wait_idle();
		e = res(c, 1'b0, 1'b0);
		rc(adc_ctrl_pkg::IDX_RES_LO, "lock lo", e[7:0]);
		SAMPLE_CODE <= ~c;
		wr(adc_ctrl_pkg::IDX_CTRL_A, 8'hC0);
		wait_idle();
		wr(adc_ctrl_pkg::IDX_CH_CFG, 8'h20);
		e = res(c, 1'b1, 1'b0);
		rc(adc_ctrl_pkg::IDX_RES_HI, "lock hi",
			e[15:8]);
		rc(adc_ctrl_pkg::IDX_RES_LO, "left lo", e[7:0]);
		// high read releases the lock the low read just set
		rc(adc_ctrl_pkg::IDX_RES_HI, "left hi",
			e[15:8]);
		// channel change waits for the running conversion
		wr(adc_ctrl_pkg::IDX_CH_CFG, 8'h00);
		wr(adc_ctrl_pkg::IDX_CTRL_A, 8'hC0);
		wr(adc_ctrl_pkg::IDX_CH_CFG, 8'h10);
		chk("chan held", CONV_CHANNEL, 6'h00);
		wait_idle();
		// the channel is taken one edge after busy drops
		@(negedge CORE_CLK);
		chk("chan taken", CONV_CHANNEL, 6'h10);
		@(posedge CORE_CLK);
		c = 10'(xs());
		SAMPLE_CODE <= c;
		wr(adc_ctrl_pkg::IDX_CTRL_A, 8'hC0);
		wait_idle();
		e = res(c, 1'b0, 1'b1);
		rc(adc_ctrl_pkg::IDX_RES_LO, "diff lo", e[7:0]);
		rc(adc_ctrl_pkg::IDX_RES_HI, "diff hi", e[15:8]);
		wr(adc_ctrl_pkg::IDX_CH_CFG, 8'h00);
		// sources are ignored until auto-trigger is on
		wr(adc_ctrl_pkg::IDX_CTRL_B, 8'h01); // reserved bit zero
		wr(adc_ctrl_pkg::IDX_CTRL_A, 8'h80);
		TRIG_FLAGS <= 7'h7F;
		sb();
		chk("no auto", s, 1'b0);
		TRIG_FLAGS <= 7'h00;
		// each source code: other flags are noise, own flag starts
		for (int k = 1; k < 8; k++)
		begin
			wr(adc_ctrl_pkg::IDX_CTRL_B, 8'(k));
			wr(adc_ctrl_pkg::IDX_CTRL_A, 8'hA0);
			TRIG_FLAGS <= 7'(xs()) & ~(7'h01 << (k - 1));
			sb();
			chk("other src", s, 1'b0);
			TRIG_FLAGS[k-1] <= 1'b1;
			sb();
			chk("own src", s, 1'b1);
			wait_idle();
			TRIG_FLAGS <= 7'h00;
		end
		// one edge between the two flag writes keeps one driver per step
		@(posedge CORE_CLK);
		// switching onto a set source is an edge; to free running is not
		TRIG_FLAGS <= 7'h04;
		wr(adc_ctrl_pkg::IDX_CTRL_B, 8'h03);
		sb();
		chk("switch edge", s, 1'b1);
		wait_idle();
		wr(adc_ctrl_pkg::IDX_CTRL_B, 8'h00);
		sb();
		chk("free sel", s, 1'b0);
		TRIG_FLAGS <= 7'h00;
		// free running on a single-ended channel
		wr(adc_ctrl_pkg::IDX_CTRL_A, 8'hE0);
		wait_idle();
		sb();
		chk("free rerun", s, 1'b1);
		wr(adc_ctrl_pkg::IDX_CTRL_A, 8'h00);
		chk("off power", CONV_POWER, 1'b0);
		chk("off abort", CONV_BUSY, 1'b0);
		b0 = busy_cnt;
		wr(adc_ctrl_pkg::IDX_CTRL_A, 8'hC0);
		chk("on power", CONV_POWER, 1'b1);
		wait_idle();
		chk("reinit length", 16'(bl),
			16'(conv_len(1'b1, 0)));
		give_verdict();
	end

	// watchdog, well beyond the roughly 4k cycles the run needs
	initial
	begin
		repeat (60000) @(posedge CORE_CLK);
		failures++;
		give_verdict();
	end
endmodule // adc_ctrl_tb_top
